// >>> sio_i2c.sv
`timescale 1ns/10ps
// Functional notes
// - Bit counter counts SCL rising edges from zero
// - Counter wraps after nine in bus mode
// - Counter cleared on reset, stop-clock, start, mode
// - Released state shifts until wait condition met
// - Wait condition holds SCL low as master, freezes shifting
// - Forced wait lands at next-but-one SCL fall
// - Forced wait while SCL low: two more pulses
// - Re-release while released keeps state; field, ack rewritten
// - Repeated data wait re-enters wait at release
// - Master stalls while slave holds SCL low
// - Resume clock within 3.3 us after stretch
// - Resume delay T depends on clock rate
// - Software selects interrupt timing field
// - Receive drives ack at fall, count eight
// - Written ack bit holds during reception
// - Transmit samples ack at rise, count eight
// - Wait-control write also writes ack bit
// - Master drives SCL low while waiting
// - First slave select floats SCL, then holds
// - Start and busy flags track bus only
// - SCL open-drain; ack on ninth clock
// - Interrupt on count 7, 8, start-7, stop
// - Wait field: none, data, ack, address
// - Release bit starts, zero forces wait
// - Busy on start/stop; start-seen clears at 9
module sio_i2c #(
  parameter logic [15:0] HALF_DIV = sio_pkg::HALF_DIV_RESET
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic clock_stop,
  input wire logic i2c_mode,
  input wire logic master_sel,
  input wire logic tx_sel,
  input wire logic fast_clk,
  input wire logic [1:0] irq_cond_sel,
  input wire sio_pkg::sio_wctl_t wctl_wdata,
  input wire logic wctl_we,
  input wire logic ack_we,
  input wire logic [7:0] sr_wdata,
  input wire logic sr_we,
  input wire logic scl_i,
  input wire logic sda_i,
  output sio_pkg::sio_wctl_t wctl_rdata,
  output sio_pkg::sio_stat_t stat_rdata,
  output logic [7:0] sr_rdata,
  output logic serial0_irq_flag,
  output sio_pkg::sio_pins_t pins
);
  import sio_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] pin_q;
  sio_sync3 #(.WIDTH(2)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .d({scl_i, sda_i}),
    .q(pin_q)
  );
  wire scl_s = pin_q[1];
  wire sda_s = pin_q[0];
  logic scl_d_reg;
  logic sda_d_reg;
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = i2c_mode & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = i2c_mode & scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // Link-clock heartbeat, crossed back as a level
  // ----------------------------------------
  // The link clock only paces the master half-period; a toggle on it
  // is brought into ref_clk by two flops and edge-detected there.
  // rst is far shorter than a link period, so it is stretched before crossing
  logic [5:0] lrst_cnt_reg;
  logic lrst_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lrst_cnt_reg <= LINK_RST_CYC;
      lrst_reg <= 1'b1;
    end else if (ce) begin
      if (lrst_cnt_reg != 6'h00) begin
        lrst_cnt_reg <= 6'(lrst_cnt_reg - 6'h01);
      end else begin
        lrst_reg <= 1'b0;
      end
    end
  end
  logic lr1_reg;
  logic lr2_reg;
  logic link_tgl_reg;
  always_ff @(posedge link_clk) begin
    lr1_reg <= lrst_reg;
    lr2_reg <= lr1_reg;
    if (lr2_reg) begin
      link_tgl_reg <= 1'b0;
    end else begin
      link_tgl_reg <= ~link_tgl_reg;
    end
  end
  logic lk1_reg;
  logic lk2_reg;
  logic lk3_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lk1_reg <= 1'b0;
      lk2_reg <= 1'b0;
      lk3_reg <= 1'b0;
    end else if (ce) begin
      lk1_reg <= link_tgl_reg;
      lk2_reg <= lk1_reg;
      lk3_reg <= lk2_reg;
    end
  end
  wire link_tick = lk2_reg ^ lk3_reg;

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_FORCE = 3'b100
  } sio_state_t;
  sio_state_t state_reg;
  sio_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [1:0] wsel_reg;
  logic ack_reg;
  logic [7:0] sr_reg;
  logic sda_o_reg;
  logic sda_oe_reg;
  logic scl_o_reg;
  logic scl_oe_reg;
  logic start_reg;
  logic busy_reg;
  logic irq_reg;
  logic addr_arm_reg;
  logic irq_arm_reg;
  logic data_wait_prev_reg;
  logic slave_seen_reg;
  logic slave_hold_reg;
  logic slave_first_reg;
  logic mode_d_reg;
  logic [15:0] div_reg;
  logic [7:0] resume_reg;
  logic force_fall_reg;
  logic [7:0] sr_rd_reg;

  wire running = (state_reg != ST_WAIT);
  wire do_release = wctl_we & wctl_wdata.wait_release_bit;
  wire do_force = wctl_we & ~wctl_wdata.wait_release_bit;
  wire mode_to_sio = mode_d_reg & ~i2c_mode;
  wire cnt_clear = clock_stop | start_det | mode_to_sio;
  wire cnt_wrap = i2c_mode ? (cnt_reg == CNT_ACK) : (cnt_reg == CNT_EIGHT);
  wire cnt_adv = running & scl_rise;
  wire wait_hit_data = (wsel_reg == WAIT_DATA) & (cnt_reg == CNT_EIGHT);
  wire wait_hit_ack = (wsel_reg == WAIT_ACK) & (cnt_reg == CNT_ACK);
  wire wait_hit_addr = (wsel_reg == WAIT_ADDR) & addr_arm_reg & (cnt_reg == CNT_EIGHT);
  wire wait_hit = scl_fall & (wait_hit_data | wait_hit_ack | wait_hit_addr);
  wire slave_stretch = master_sel & scl_o_reg & ~scl_s;
  wire resume_ok = (resume_reg == 8'h00);
  wire [7:0] t_cyc = fast_clk ? 8'(T_FAST_CYC) : 8'(T_SLOW_CYC);
  wire rx_ack_slot = i2c_mode & ~tx_sel & (cnt_reg == CNT_EIGHT) & scl_fall;
  wire tx_ack_slot = i2c_mode & tx_sel & (cnt_reg == CNT_EIGHT) & scl_rise;

  // ----------------------------------------
  // Wait state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        if (do_release) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (do_force) begin
          state_next = ST_FORCE;
        end else if (wait_hit) begin
          state_next = ST_WAIT;
        end
      end
      ST_FORCE: begin
        if (scl_fall & force_fall_reg) begin
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_clear) begin
      cnt_next = CNT_ZERO;
    end else if (cnt_adv & (state_reg != ST_FORCE | ~scl_d_reg)) begin
      cnt_next = cnt_wrap ? CNT_ZERO : 4'(cnt_reg + 4'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_WAIT;
      cnt_reg <= CNT_ZERO;
      wsel_reg <= WAIT_NONE;
      data_wait_prev_reg <= 1'b0;
      mode_d_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      force_fall_reg <= 1'b0;
    end else if (ce) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      mode_d_reg <= i2c_mode;
      if (clock_stop) begin
        state_reg <= ST_WAIT;
      end else if (do_release & running) begin
        state_reg <= state_reg;
      end else if (do_release & data_wait_prev_reg & (wctl_wdata.wait_cond_sel_lo
                   & ~wctl_wdata.wait_cond_sel_hi) & (cnt_reg == CNT_EIGHT)) begin
        state_reg <= ST_WAIT;
      end else begin
        state_reg <= state_next;
      end
      cnt_reg <= cnt_next;
      if (do_force) begin
        force_fall_reg <= 1'b0;
      end else if (scl_fall) begin
        force_fall_reg <= 1'b1;
      end
      if (clock_stop) begin
        wsel_reg <= WAIT_NONE;
        data_wait_prev_reg <= 1'b0;
      end else if (wctl_we) begin
        wsel_reg <= {wctl_wdata.wait_cond_sel_hi, wctl_wdata.wait_cond_sel_lo};
        data_wait_prev_reg <= ({wctl_wdata.wait_cond_sel_hi,
                                wctl_wdata.wait_cond_sel_lo} == WAIT_DATA);
      end
    end
  end

  // ----------------------------------------
  // Shift register and acknowledge
  // ----------------------------------------
  wire sr_shift = cnt_adv & (cnt_reg < CNT_EIGHT) & (state_reg != ST_FORCE | ~scl_d_reg);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sr_reg <= 8'h00;
      ack_reg <= 1'b0;
      sr_rd_reg <= 8'h00;
    end else if (ce) begin
      if (sr_we & ~running) begin
        sr_reg <= sr_wdata;
      end else if (sr_shift) begin
        sr_reg <= {sr_reg[6:0], sda_s};
      end
      if (clock_stop) begin
        ack_reg <= 1'b0;
      end else if (tx_ack_slot & running) begin
        ack_reg <= sda_s;
      end else if (ack_we | wctl_we) begin
        ack_reg <= wctl_wdata.ack_bit;
      end
      sr_rd_reg <= sr_reg;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda_o_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else if (ce) begin
      if (!i2c_mode) begin
        sda_oe_reg <= 1'b0;
      end else if (do_release & ~running & tx_sel & (cnt_reg < CNT_EIGHT)) begin
        sda_o_reg <= sr_reg[7];
        sda_oe_reg <= ~sr_reg[7];
      end else if (rx_ack_slot & running) begin
        sda_o_reg <= ack_reg;
        sda_oe_reg <= ~ack_reg;
      end else if (scl_fall & running & tx_sel & (cnt_reg < CNT_EIGHT)) begin
        sda_o_reg <= sr_reg[7];
        sda_oe_reg <= ~sr_reg[7];
      end else if (scl_fall & running) begin
        sda_oe_reg <= 1'b0; // Release for ack or receive
      end
    end
  end

  // Master clock: half-period counter on the link heartbeat, held off
  // while a slave stretches and for T after it lets go.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_o_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      div_reg <= 16'h0000;
      resume_reg <= 8'h00;
      slave_seen_reg <= 1'b0;
      slave_hold_reg <= 1'b0;
      slave_first_reg <= 1'b0;
    end else if (ce) begin
      if (running) begin
        slave_first_reg <= 1'b0;
      end
      if (!i2c_mode) begin
        scl_oe_reg <= 1'b0;
      end else if (master_sel) begin
        if (!running) begin
          scl_o_reg <= 1'b0;
          scl_oe_reg <= 1'b1;
          div_reg <= 16'h0000;
        end else if (slave_stretch) begin
          resume_reg <= t_cyc;
        end else if (!resume_ok) begin
          resume_reg <= 8'(resume_reg - 8'h01);
        end else if (link_tick) begin
          if (div_reg >= HALF_DIV) begin
            div_reg <= 16'h0000;
            scl_o_reg <= ~scl_o_reg;
            scl_oe_reg <= scl_o_reg; // Low drives, high floats
          end else begin
            div_reg <= 16'(div_reg + 16'h0001);
          end
        end
      end else begin
        // Only the first slave session after power-up holds a low clock
        if (!slave_seen_reg) begin
          slave_seen_reg <= 1'b1;
          slave_first_reg <= 1'b1;
          scl_oe_reg <= 1'b0;
        end else if (running) begin
          slave_hold_reg <= 1'b0;
          scl_oe_reg <= 1'b0;
        end else if ((~scl_s & slave_first_reg) | slave_hold_reg) begin
          slave_hold_reg <= 1'b1;
          scl_o_reg <= 1'b0;
          scl_oe_reg <= 1'b1;
        end else begin
          scl_oe_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Bus flags and interrupt
  // ----------------------------------------
  wire irq_hit =
    (irq_cond_sel == IRQ_CNT7) ? (cnt_adv & cnt_next == CNT_SEVEN) :
    (irq_cond_sel == IRQ_CNT8) ? (cnt_adv & cnt_next == CNT_EIGHT) :
    (irq_cond_sel == IRQ_START7) ? (irq_arm_reg & cnt_adv & cnt_next == CNT_SEVEN) :
    stop_det;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
      irq_reg <= 1'b0;
      addr_arm_reg <= 1'b0;
      irq_arm_reg <= 1'b0;
    end else if (ce) begin
      if (!i2c_mode | clock_stop) begin
        start_reg <= 1'b0;
        busy_reg <= 1'b0;
      end else begin
        if (start_det) begin
          start_reg <= 1'b1;
        end else if (scl_rise & cnt_reg == CNT_ACK) begin
          start_reg <= 1'b0;
        end
        if (start_det) begin
          busy_reg <= 1'b1;
        end else if (stop_det) begin
          busy_reg <= 1'b0;
        end
      end
      if (start_det) begin
        addr_arm_reg <= 1'b1;
        irq_arm_reg <= 1'b1;
      end else begin
        if (wait_hit_addr & scl_fall) begin
          addr_arm_reg <= 1'b0;
        end
        if (irq_hit & irq_cond_sel == IRQ_START7) begin
          irq_arm_reg <= 1'b0;
        end
      end
      irq_reg <= irq_hit & i2c_mode;
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wctl_rdata <= '0;
      stat_rdata <= '0;
      serial0_irq_flag <= 1'b0;
      pins <= '{scl_o: 1'b1, scl_oe: 1'b0, sda_o: 1'b1, sda_oe: 1'b0};
    end else if (ce) begin
      wctl_rdata <= '{ack_bit: ack_reg & i2c_mode, wait_release_bit: running,
                      wait_cond_sel_hi: wsel_reg[1], wait_cond_sel_lo: wsel_reg[0]};
      stat_rdata <= '{start_seen_flag: start_reg, bus_busy_flag: busy_reg,
                      cnt_is_9: cnt_reg == CNT_ACK, cnt_is_8: cnt_reg == CNT_EIGHT};
      serial0_irq_flag <= irq_reg;
      pins <= '{scl_o: scl_o_reg, scl_oe: scl_oe_reg, sda_o: sda_o_reg, sda_oe: sda_oe_reg};
    end
  end
  assign sr_rdata = sr_rd_reg;
endmodule // sio_i2c

// >>> sio_i2c_bench.sv
`timescale 1ns/10ps
module sio_i2c_bench;
  import sio_pkg::*;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic clock_stop = 1'b0;
  logic i2c_mode = 1'b1;
  logic master_sel = 1'b0;
  logic tx_sel = 1'b0;
  logic fast_clk = 1'b0;
  logic [1:0] irq_cond_sel = IRQ_CNT7;
  sio_wctl_t wctl_wdata = '0;
  logic wctl_we = 1'b0;
  logic [7:0] sr_wdata = 8'h00;
  logic sr_we = 1'b0;
  logic scl_w;
  logic sda_w;
  logic scl_low;
  logic sda_low;
  logic [7:0] rx_byte;
  logic [7:0] rx_n;
  sio_wctl_t wctl_rdata;
  sio_stat_t stat_rdata;
  logic [7:0] sr_rdata;
  logic serial0_irq_flag;
  sio_pins_t pins;
  logic [31:0] rnd = 32'hd9eb6461;
  logic [7:0] exp_q[$];
  logic ack_exp;
  int err_total = 0;
  int check_count = 0;
  int irq_cnt = 0;
  // ------
  // Clocks, wired bus, design and far station
  // ------
  always #2 ref_clk = ~ref_clk;
  always #40 link_clk = ~link_clk;
  assign scl_w = !((pins.scl_oe && !pins.scl_o) || scl_low);
  assign sda_w = !((pins.sda_oe && !pins.sda_o) || sda_low);
  sio_i2c #(.HALF_DIV(16'h0002)) u_sio_i2c (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .link_clk(link_clk), .clock_stop(clock_stop), .i2c_mode(i2c_mode),
    .master_sel(master_sel), .tx_sel(tx_sel), .fast_clk(fast_clk),
    .irq_cond_sel(irq_cond_sel), .wctl_wdata(wctl_wdata), .wctl_we(wctl_we),
    .ack_we(1'b0), .sr_wdata(sr_wdata), .sr_we(sr_we), .scl_i(scl_w), .sda_i(sda_w),
    .wctl_rdata(wctl_rdata), .stat_rdata(stat_rdata), .sr_rdata(sr_rdata),
    .serial0_irq_flag(serial0_irq_flag), .pins(pins));
  sio_i2c_peer u_sio_i2c_peer (.scl(scl_w), .sda(sda_w), .scl_low(scl_low),
    .sda_low(sda_low), .rx_byte(rx_byte), .rx_n(rx_n));
  // ------
  // Helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_rel(input logic lvl);
    int i;
    for (i = 0; i < 20000 && wctl_rdata.wait_release_bit !== lvl; i++) begin
      tick(1);
    end
    if (i == 20000) begin
      err_total++;
      end_sim();
    end
  endtask
  // Release with a wait condition, then ride the transfer out to the next wait
  task automatic wctl_write(input logic [1:0] cond);
    tick(1);
    wctl_wdata = {1'b0, 1'b1, cond};
    wctl_we = 1'b1;
    tick(1);
    wctl_we = 1'b0;
    wait_rel(1'b1);
    wait_rel(1'b0);
  endtask
  // ------
  // Monitors: bytes seen on the wire are matched against the oldest note
  // ------
  always @(posedge ref_clk) begin
    if (serial0_irq_flag === 1'b1) begin
      irq_cnt++;
    end
  end
  always @(rx_n) begin
    if (rx_n != 8'h00) begin
      check(rx_byte, (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_byte);
    end
  end
  // ------
  // Main sequence
  // ------
  initial begin
    tick(2);
    rst = 1'b0;
    tick(3);
    check({2'b00, pins.scl_oe, pins.sda_oe, stat_rdata}, 8'h00);
    $display("Test reset done");
    fast_clk = rnd[0];
    u_sio_i2c_peer.do_start();
    tick(20);
    check({4'h0, stat_rdata}, 8'h0c);
    $display("Test start done");
    master_sel = 1'b1;
    tx_sel = 1'b1;
    tick(10);
    check({6'h00, pins.scl_oe, pins.scl_o}, 8'h02);
    rnd = lfsr(rnd);
    sr_wdata = rnd[7:0];
    sr_we = 1'b1;
    exp_q.push_back(rnd[7:0]);
    tick(1);
    sr_we = 1'b0;
    ack_exp = rnd[8];
    u_sio_i2c_peer.ack_val = ack_exp;
    u_sio_i2c_peer.ack_drive = 1'b1;
    u_sio_i2c_peer.stretch_en = 1'b1;
    wctl_write(WAIT_DATA);
    tick(100);
    check({4'h0, stat_rdata}, 8'h0d);
    check({6'h00, pins.scl_oe, pins.scl_o}, 8'h02);
    check(8'(irq_cnt), 8'h01);
    check(8'(exp_q.size()), 8'h00);
    check(sr_rdata, sr_wdata);
    $display("Test data byte done");
    irq_cond_sel = IRQ_STOP;
    wctl_write(WAIT_ACK);
    check({7'h00, wctl_rdata.ack_bit}, {7'h00, ack_exp});
    check({4'h0, stat_rdata}, 8'h0e);
    $display("Test ack done");
    u_sio_i2c_peer.sda_low = 1'b1;
    tick(10);
    master_sel = 1'b0;
    tx_sel = 1'b0;
    tick(30);
    u_sio_i2c_peer.sda_low = 1'b0;
    tick(20);
    check(8'(irq_cnt), 8'h02);
    check({6'h00, stat_rdata.start_seen_flag, stat_rdata.bus_busy_flag}, 8'h00);
    $display("Test stop done");
    i2c_mode = 1'b0;
    tick(10);
    check({4'h0, stat_rdata}, 8'h00);
    i2c_mode = 1'b1;
    clock_stop = 1'b1;
    tick(5);
    clock_stop = 1'b0;
    check({4'h0, wctl_rdata}, 8'h00);
    $display("Test mode and clock stop done");
    end_sim();
  end
endmodule // sio_i2c_bench

// >>> sio_i2c_peer.sv
`timescale 1ns/10ps
module sio_i2c_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_n
);
  // ------
  // Far station, slave receiver; it only ever pulls lines low
  // ------
  logic [3:0] bits = 4'h0;
  logic ack_drive = 1'b0;
  logic ack_val = 1'b1;
  logic stretch_en = 1'b0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    rx_n = 8'h00;
  end
  always @(posedge scl) begin
    if (bits == 4'h8) begin
      bits = 4'h0;
    end else begin
      rx_byte = {rx_byte[6:0], sda};
      bits = bits + 4'h1;
      if (bits == 4'h8) begin
        rx_n = rx_n + 8'h01;
      end
    end
  end
  // Stretch blocks this process, so no edge is seen while it holds the clock
  always @(negedge scl) begin
    sda_low = ack_drive && !ack_val && (bits == 4'h8);
    if (stretch_en && bits == 4'h3) begin
      scl_low = 1'b1;
      #2000;
      scl_low = 1'b0;
    end
  end
  task automatic do_start();
    bits = 4'h0;
    sda_low = 1'b1;
  endtask
endmodule // sio_i2c_peer

// >>> sio_i2c_sva.sv
`timescale 1ns/10ps
module sio_i2c_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic i2c_mode,
  input wire logic master_sel,
  input wire logic clock_stop,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wctl_we,
  input wire sio_pkg::sio_wctl_t wctl_wdata,
  input wire sio_pkg::sio_wctl_t wctl_rdata,
  input wire sio_pkg::sio_stat_t stat_rdata,
  input wire logic serial0_irq_flag,
  input wire sio_pkg::sio_pins_t pins
);
  import sio_pkg::*;
  // ------
  // Port relations
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_scl_open_drain: assert property (pins.scl_oe |-> !pins.scl_o)
    else $error("Clock pin driven high");
  chk_cnt_exclusive: assert property (!(stat_rdata.cnt_is_8 && stat_rdata.cnt_is_9))
    else $error("Both count flags set");
  chk_irq_single: assert property (serial0_irq_flag |=> !serial0_irq_flag)
    else $error("Interrupt pulse too long");
  chk_serial_flags_zero: assert property (!i2c_mode [*4] |->
    !stat_rdata.start_seen_flag && !stat_rdata.bus_busy_flag)
    else $error("Bus flags set in serial mode");
  chk_stop_clears_all: assert property (clock_stop [*4] |->
    stat_rdata == '0 && !wctl_rdata.wait_release_bit)
    else $error("Clock stop did not clear");
  chk_wait_scl_low: assert property ((i2c_mode && master_sel && !clock_stop
    && !wctl_rdata.wait_release_bit) [*4] |-> pins.scl_oe && !pins.scl_o)
    else $error("Waiting master left clock free");
  chk_busy_on_start: assert property ($fell(sda_i) && scl_i && $past(scl_i) &&
    i2c_mode |-> ##[1:10] stat_rdata.bus_busy_flag)
    else $error("Start not flagged");
  chk_busy_off_stop: assert property ($rose(sda_i) && scl_i && $past(scl_i) &&
    i2c_mode |-> ##[1:10] !stat_rdata.bus_busy_flag)
    else $error("Stop not flagged");
  chk_start_clr_cnt: assert property ($fell(sda_i) && scl_i && $past(scl_i) &&
    i2c_mode |-> ##[1:10] !stat_rdata.cnt_is_8 && !stat_rdata.cnt_is_9)
    else $error("Start left count set");
  chk_release_reads_one: assert property (wctl_we && wctl_wdata.wait_release_bit &&
    i2c_mode && !clock_stop |-> ##2 wctl_rdata.wait_release_bit)
    else $error("Release not reported");
endmodule // sio_i2c_chk

bind sio_i2c sio_i2c_chk u_sio_i2c_chk (.ref_clk(ref_clk), .rst(rst), .i2c_mode(i2c_mode),
  .master_sel(master_sel), .clock_stop(clock_stop), .scl_i(scl_i), .sda_i(sda_i),
  .wctl_we(wctl_we), .wctl_wdata(wctl_wdata), .wctl_rdata(wctl_rdata),
  .stat_rdata(stat_rdata), .serial0_irq_flag(serial0_irq_flag), .pins(pins));

// >>> sio_pkg.sv
package sio_pkg;
  // ----------------------------------------
  // Counter and event constants
  // ----------------------------------------
  localparam logic [3:0] CNT_ACK = 4'h9;
  localparam logic [3:0] CNT_EIGHT = 4'h8;
  localparam logic [3:0] CNT_SEVEN = 4'h7;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_DATA = 2'h1;
  localparam logic [1:0] WAIT_ACK = 2'h2;
  localparam logic [1:0] WAIT_ADDR = 2'h3;
  localparam logic [1:0] IRQ_CNT7 = 2'h0;
  localparam logic [1:0] IRQ_CNT8 = 2'h1;
  localparam logic [1:0] IRQ_START7 = 2'h2;
  localparam logic [1:0] IRQ_STOP = 2'h3;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESUME_MAX_PS = 3300000;
  localparam int RESUME_MAX_CYC = RESUME_MAX_PS / CLK_PERIOD_PS;
  localparam int T_SLOW_PS = 666000;
  localparam int T_FAST_PS = 222000;
  localparam int T_SLOW_CYC = T_SLOW_PS / CLK_PERIOD_PS;
  localparam int T_FAST_CYC = T_FAST_PS / CLK_PERIOD_PS;
  localparam logic [15:0] HALF_DIV_RESET = 16'h0535;
  localparam logic [5:0] LINK_RST_CYC = 6'h3f;

  typedef struct packed {
    logic ack_bit;
    logic wait_release_bit;
    logic wait_cond_sel_hi;
    logic wait_cond_sel_lo;
  } sio_wctl_t;

  typedef struct packed {
    logic start_seen_flag;
    logic bus_busy_flag;
    logic cnt_is_9;
    logic cnt_is_8;
  } sio_stat_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } sio_pins_t;
endpackage

// >>> sio_sync3.sv
`timescale 1ns/10ps
module sio_sync3 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] q_reg;
  // --------------------------------
  // Accept a change once stages 2 and 3 agree
  // --------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_reg[i] <= 1'b1;
          s2_reg[i] <= 1'b1;
          s3_reg[i] <= 1'b1;
          q_reg[i] <= 1'b1;
        end else if (ce) begin
          s1_reg[i] <= d[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            q_reg[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate
  assign q = q_reg;
endmodule // sio_sync3
